// ==== src/qdc_serial_top.sv ====
// serial slave readback engine and power-down control for the quad converter
// Behaviour
// - the entry code is never acknowledged; data line stays released.
// - write-addressed byte with matching address is acknowledged by pulling data low.
// - control byte holds ext address, load, select and power-down flag; acknowledged.
// - read-addressed byte is acknowledged, then the block transmits data bytes.
// - with power-down flag clear, exactly two bytes return: high then low.
// - with flag set, three bytes: mode byte with ones below, high, low.
// - channel-select bits pick which channel's data is returned.
// - high byte carries the 8-bit code msb first; low byte is filler.
// - reset clears every channel output register to zero.
// - mode bits pick floating, 1k pull down, 100k pull down, floating.
// - flag clear means normal drive from the amplifier with the data code.
// - in power-down the amplifier is disconnected and the chosen load applied.
// - entering power-down leaves the stored code untouched.
// - each channel has 10-bit temporary and output registers, mode above code.
// - with flag set, first data byte bits 7:6 go to register bits 9:8.
// - power-down travels the same load and update paths as data.
`timescale 1ns/1ps
module qdc_serial_top
  import qdc_pkg::*;
#(
  parameter int CHANNELS = 4
)
(
  // clocking
  input wire logic SYS_CLK_I,
  input wire logic SYS_RST_I,
  input wire logic CE_I,
  // two-wire serial port
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  // address straps
  input wire logic [1:0] ADDR_PIN_I,
  input wire logic [1:0] ADDR_EXT_I,
  // analog-side controls
  output logic [CHANNELS*8-1:0] CODE_O,
  output logic [CHANNELS-1:0] AMP_EN_O,
  output logic [CHANNELS-1:0] PULL_1K_O,
  output logic [CHANNELS-1:0] PULL_100K_O
);
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_ADDR = 10'h002,
    ST_ADDR_ACK = 10'h004,
    ST_CTRL = 10'h008,
    ST_CTRL_ACK = 10'h010,
    ST_WDATA = 10'h020,
    ST_WDATA_ACK = 10'h040,
    ST_RDATA = 10'h080,
    ST_RDATA_ACK = 10'h100,
    ST_IGNORE = 10'h200
  } qdc_state_t;

  qdc_state_t state;
  qdc_state_t next_state;
  logic scl;
  logic sda;
  logic scl_d;
  logic sda_d;
  logic [1:0] pin_addr;
  logic [1:0] ext_addr;
  logic [7:0] shift;
  logic [2:0] bit_cnt;
  logic byte_done;
  logic rw;
  logic addr_hit;
  logic [7:0] ctrl;
  logic wr_low;
  logic [7:0] hi_byte;
  logic [1:0] rd_idx;
  logic [7:0] cur_byte;
  logic rb_pd;
  logic [1:0] rb_mode;
  logic [7:0] rb_code;

  // bus events from the filtered levels
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign scl_rise = scl && !scl_d;
  assign scl_fall = !scl && scl_d;
  assign start_ev = scl && scl_d && sda_d && !sda;
  assign stop_ev = scl && scl_d && !sda_d && sda;

  // decoded fields of the byte just shifted in and of the stored control byte
  logic [7:0] rx_byte;
  logic addr_match;
  logic ext_match;
  logic ctrl_pd;
  logic [1:0] ctrl_sel;
  logic [1:0] ctrl_load;
  logic [1:0] rd_total;
  logic rd_last;
  logic wr_commit;
  assign rx_byte = {shift[6:0], sda};
  assign addr_match = shift[6:2] == QDC_ADDR_FIXED && shift[1:0] == pin_addr;
  assign ext_match = ctrl[QDC_CTRL_EXT_HI:QDC_CTRL_EXT_LO] == ext_addr;
  assign ctrl_pd = ctrl[QDC_CTRL_PD];
  assign ctrl_sel = ctrl[QDC_CTRL_SEL_HI:QDC_CTRL_SEL_LO];
  assign ctrl_load = ctrl[QDC_CTRL_LOAD_HI:QDC_CTRL_LOAD_LO];
  assign rd_total = ctrl_pd ? QDC_RD_BYTES_PD : QDC_RD_BYTES_NORM;
  assign rd_last = rd_idx == rd_total - 2'd1;
  assign wr_commit = CE_I && state == ST_WDATA_ACK && scl_fall && wr_low && ext_match;

  // byte to send for a given position of the readback
  function automatic logic [7:0] qdc_tx_byte(input logic [1:0] idx, input logic pd,
                                             input logic [1:0] mode, input logic [7:0] code);
    if (pd && idx == 2'd0)
      qdc_tx_byte = {mode, QDC_PD_FILL};
    else if (idx == (pd ? 2'd1 : 2'd0))
      qdc_tx_byte = code;
    else
      qdc_tx_byte = QDC_LOW_FILL;
  endfunction

  // serial pins pass the agreement filter before any edge detection
  qdc_pin_sync #(
    .WIDTH(2)
  ) u_bus_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(SYS_RST_I),
    .ce_i(CE_I),
    .pin_i({SCL_I, SDA_I}),
    .init_i(2'b11),
    .level_o({scl, sda})
  );

  // address straps are static but still come from outside the clock domain
  qdc_pin_sync #(
    .WIDTH(4)
  ) u_addr_sync (
    .clk_i(SYS_CLK_I),
    .rst_i(SYS_RST_I),
    .ce_i(CE_I),
    .pin_i({ADDR_EXT_I, ADDR_PIN_I}),
    .init_i(4'hF),
    .level_o({ext_addr, pin_addr})
  );

  // channel registers; the low byte of a write commits the pair
  qdc_chan_bank #(
    .CHANNELS(CHANNELS)
  ) u_bank (
    .clk_i(SYS_CLK_I),
    .rst_i(SYS_RST_I),
    .ce_i(CE_I),
    .wr_i(wr_commit),
    .sel_i(ctrl_sel),
    .pd_i(ctrl_pd),
    .load_i(ctrl_load),
    .byte_i(hi_byte),
    .rb_pd_o(rb_pd),
    .rb_mode_o(rb_mode),
    .rb_code_o(rb_code),
    .code_o(CODE_O),
    .amp_en_o(AMP_EN_O),
    .pull_1k_o(PULL_1K_O),
    .pull_100k_o(PULL_100K_O)
  );

  // next state; start and stop override every byte phase
  always_comb
  begin
    next_state = state;
    if (start_ev)
      next_state = ST_ADDR;
    else if (stop_ev)
      next_state = ST_IDLE;
    else
    begin
      unique case (state)
        ST_IDLE, ST_IGNORE: next_state = state;
        ST_ADDR:
          if (scl_fall && byte_done)
            next_state = addr_hit ? ST_ADDR_ACK : ST_IGNORE;
        ST_ADDR_ACK:
          if (scl_fall)
            next_state = rw ? ST_RDATA : ST_CTRL;
        ST_CTRL:
          if (scl_fall && byte_done)
            next_state = ST_CTRL_ACK;
        ST_CTRL_ACK:
          if (scl_fall)
            next_state = ST_WDATA;
        ST_WDATA:
          if (scl_fall && byte_done)
            next_state = ST_WDATA_ACK;
        ST_WDATA_ACK:
          if (scl_fall)
            next_state = ST_WDATA;
        ST_RDATA:
          if (scl_fall && byte_done)
            next_state = ST_RDATA_ACK;
        ST_RDATA_ACK:
          if (scl_rise && sda)
            next_state = ST_IGNORE;
          else if (scl_fall)
            next_state = rd_last ? ST_IGNORE : ST_RDATA;
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // state register and edge history
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      state <= ST_IDLE;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else if (CE_I)
    begin
      state <= next_state;
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  // receive shifter and bit counter; data is sampled on the rising clock
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      shift <= QDC_BYTE_RESET;
      bit_cnt <= 3'd0;
      byte_done <= 1'b0;
    end
    else if (CE_I)
    begin
      if (start_ev || next_state != state)
      begin
        bit_cnt <= 3'd0;
        byte_done <= 1'b0;
      end
      else if (scl_rise && state != ST_RDATA)
      begin
        shift <= rx_byte;
        bit_cnt <= bit_cnt + 3'd1;
        byte_done <= bit_cnt == QDC_LAST_BIT;
      end
      else if (scl_rise)
      begin
        bit_cnt <= bit_cnt + 3'd1;
        byte_done <= bit_cnt == QDC_LAST_BIT;
      end
    end
  end

  // protocol registers captured at the end of the address, control and first data bytes
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      rw <= 1'b0;
      addr_hit <= 1'b0;
      ctrl <= QDC_BYTE_RESET;
      hi_byte <= QDC_BYTE_RESET;
      wr_low <= 1'b0;
    end
    else if (CE_I)
    begin
      if (state == ST_ADDR && scl_rise && bit_cnt == QDC_LAST_BIT)
      begin
        rw <= sda;
        addr_hit <= addr_match;
      end
      if (state == ST_CTRL && scl_rise && bit_cnt == QDC_LAST_BIT)
      begin
        ctrl <= rx_byte;
        wr_low <= 1'b0;
      end
      if (state == ST_WDATA && scl_rise && bit_cnt == QDC_LAST_BIT && !wr_low)
        hi_byte <= rx_byte;
      if (state == ST_WDATA_ACK && scl_fall)
        wr_low <= !wr_low;
    end
  end

  // transmit side: readback position and current byte
  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      rd_idx <= 2'd0;
      cur_byte <= QDC_BYTE_RESET;
    end
    else if (CE_I)
    begin
      if (state == ST_ADDR_ACK && scl_fall)
      begin
        rd_idx <= 2'd0;
        cur_byte <= qdc_tx_byte(2'd0, ctrl_pd, rb_mode, rb_code);
      end
      else if (state == ST_RDATA_ACK && scl_fall && !rd_last)
      begin
        rd_idx <= rd_idx + 2'd1;
        cur_byte <= qdc_tx_byte(rd_idx + 2'd1, ctrl_pd, rb_mode, rb_code);
      end
      else if (state == ST_RDATA && scl_fall && !byte_done)
        cur_byte <= {cur_byte[6:0], 1'b1};
    end
  end

  // data line drive changes on a falling clock, or is released at start and stop; open-drain, so only zeros go out
  logic next_oe;
  logic [7:0] tx_first;
  logic [7:0] tx_next;
  // named so their top bits can be picked; a function result cannot be indexed
  assign tx_first = qdc_tx_byte(2'd0, ctrl_pd, rb_mode, rb_code);
  assign tx_next = qdc_tx_byte(rd_idx + 2'd1, ctrl_pd, rb_mode, rb_code);
  assign next_oe = (next_state == ST_ADDR_ACK) || (next_state == ST_CTRL_ACK) ||
                   (next_state == ST_WDATA_ACK) ||
                   (next_state == ST_RDATA && state == ST_ADDR_ACK && !tx_first[7]);

  always_ff @(posedge SYS_CLK_I)
  begin
    if (SYS_RST_I)
    begin
      SDA_OE_O <= 1'b0;
      SDA_O <= 1'b0;
    end
    else if (CE_I)
    begin
      SDA_O <= 1'b0;
      if (start_ev || stop_ev)
        SDA_OE_O <= 1'b0;
      else if (scl_fall)
      begin
        if (state == ST_RDATA && !byte_done)
          SDA_OE_O <= !cur_byte[6];
        else if (state == ST_RDATA_ACK && next_state == ST_RDATA)
          SDA_OE_O <= !tx_next[7];
        else
          SDA_OE_O <= next_oe;
      end
    end
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  property p_ignore_released;
    (state == ST_IGNORE && $past(state) == ST_IGNORE) |-> !SDA_OE_O;
  endproperty
  a_ignore_released: assert property (p_ignore_released) else $error("drive while ignoring");

  property p_ack_needs_match;
    (state == ST_ADDR_ACK) |-> addr_hit;
  endproperty
  a_ack_needs_match: assert property (p_ack_needs_match) else $error("ack without match");

  property p_ctrl_ack;
    (CE_I && state == ST_CTRL && byte_done && scl_fall && !start_ev && !stop_ev) |=> SDA_OE_O;
  endproperty
  a_ctrl_ack: assert property (p_ctrl_ack) else $error("control byte not acked");

  property p_read_enter;
    (CE_I && state == ST_ADDR_ACK && scl_fall && rw && !start_ev && !stop_ev)
      |=> state == ST_RDATA && rd_idx == 2'd0;
  endproperty
  a_read_enter: assert property (p_read_enter) else $error("read not entered");

  property p_byte_count;
    (state == ST_RDATA) |-> rd_idx < rd_total;
  endproperty
  a_byte_count: assert property (p_byte_count) else $error("too many read bytes");

  property p_pd_byte;
    (state == ST_RDATA && ctrl_pd && rd_idx == 2'd0 && bit_cnt == 3'd0 && !byte_done)
      |-> cur_byte == {rb_mode, QDC_PD_FILL};
  endproperty
  a_pd_byte: assert property (p_pd_byte) else $error("bad power-down byte");

  property p_high_byte;
    (state == ST_RDATA && rd_idx == (ctrl_pd ? 2'd1 : 2'd0) && bit_cnt == 3'd0 && !byte_done)
      |-> cur_byte == rb_code;
  endproperty
  a_high_byte: assert property (p_high_byte) else $error("bad high byte");

  property p_nack_ends;
    (CE_I && state == ST_RDATA_ACK && scl_rise && sda && !start_ev && !stop_ev)
      |=> state == ST_IGNORE ##1 !SDA_OE_O;
  endproperty
  a_nack_ends: assert property (p_nack_ends) else $error("nack did not end read");

  c_read_pd: cover property (state == ST_RDATA && ctrl_pd && rd_idx == 2'd2);
  c_read_norm: cover property (state == ST_RDATA_ACK && !ctrl_pd && rd_idx == 2'd1);
  c_hs_code: cover property (state == ST_ADDR && byte_done && shift[7:3] == QDC_HS_CODE_TOP);
  c_write: cover property (wr_commit);
endmodule

// ==== src/qdc_pkg.sv ====
// shared constants for the quad converter serial control block
package qdc_pkg;
  // serial slave addressing
  localparam logic [4:0] QDC_ADDR_FIXED = 5'h13;
  localparam logic [4:0] QDC_HS_CODE_TOP = 5'h01;
  localparam logic [2:0] QDC_LAST_BIT = 3'h7;
  // control byte field positions
  localparam int QDC_CTRL_EXT_HI = 7;
  localparam int QDC_CTRL_EXT_LO = 6;
  localparam int QDC_CTRL_LOAD_HI = 5;
  localparam int QDC_CTRL_LOAD_LO = 4;
  localparam int QDC_CTRL_SEL_HI = 2;
  localparam int QDC_CTRL_SEL_LO = 1;
  localparam int QDC_CTRL_PD = 0;
  // load field encodings
  localparam logic [1:0] QDC_LOAD_NONE = 2'h0;
  localparam logic [1:0] QDC_LOAD_SEL = 2'h1;
  // power-down modes held in the upper two bits of a channel register
  localparam logic [1:0] QDC_MODE_1K = 2'h1;
  localparam logic [1:0] QDC_MODE_100K = 2'h2;
  // readback framing
  localparam logic [5:0] QDC_PD_FILL = 6'h3F;
  localparam logic [7:0] QDC_LOW_FILL = 8'h00;
  localparam logic [1:0] QDC_RD_BYTES_NORM = 2'h2;
  localparam logic [1:0] QDC_RD_BYTES_PD = 2'h3;
  // reset values
  localparam logic [9:0] QDC_CHAN_RESET = 10'h000;
  localparam logic [7:0] QDC_BYTE_RESET = 8'h00;
endpackage

// ==== src/qdc_pin_sync.sv ====
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
module qdc_pin_sync
  import qdc_pkg::*;
#(
  parameter int WIDTH = 2
)
(
  // clocking
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // pins and filtered levels
  input wire logic [WIDTH-1:0] pin_i,
  input wire logic [WIDTH-1:0] init_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // a bit changes only once the two later stages agree
  assign next_level = (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & level_o);

  // stage1 feeds stage2 only, never the filter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stage1 <= '1;
      stage2 <= '1;
      stage3 <= '1;
      level_o <= '1;
    end
    else if (ce_i)
    begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
      level_o <= next_level;
    end
  end

  logic unused_init;
  assign unused_init = ^init_i;
endmodule

// ==== src/qdc_chan_bank.sv ====
// per-channel temporary and output registers with power-down decode
`timescale 1ns/1ps
module qdc_chan_bank
  import qdc_pkg::*;
#(
  parameter int CHANNELS = 4
)
(
  // clocking
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // write request from the serial engine
  input wire logic wr_i,
  input wire logic [1:0] sel_i,
  input wire logic pd_i,
  input wire logic [1:0] load_i,
  input wire logic [7:0] byte_i,
  // readback of the selected output register
  output logic rb_pd_o,
  output logic [1:0] rb_mode_o,
  output logic [7:0] rb_code_o,
  // analog-side controls
  output logic [CHANNELS*8-1:0] code_o,
  output logic [CHANNELS-1:0] amp_en_o,
  output logic [CHANNELS-1:0] pull_1k_o,
  output logic [CHANNELS-1:0] pull_100k_o
);
  logic [9:0] tr [CHANNELS];
  logic [9:0] dr [CHANNELS];
  logic [CHANNELS-1:0] tr_pd;
  logic [CHANNELS-1:0] dr_pd;
  logic [9:0] merged;

  // power-down writes keep the stored code and only replace the mode bits
  function automatic logic [9:0] qdc_merge(input logic [9:0] old, input logic pd,
                                           input logic [7:0] b);
    qdc_merge = pd ? {b[7:6], old[7:0]} : {2'b00, b};
  endfunction

  assign merged = qdc_merge(tr[sel_i], pd_i, byte_i);

  // mode and data share one load path, so broadcast updates carry power-down too
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < CHANNELS; i++)
    begin
      if (rst_i)
      begin
        tr[i] <= QDC_CHAN_RESET;
        dr[i] <= QDC_CHAN_RESET;
        tr_pd[i] <= 1'b0;
        dr_pd[i] <= 1'b0;
      end
      else if (ce_i && wr_i)
      begin
        if (i == int'(sel_i))
        begin
          tr[i] <= merged;
          tr_pd[i] <= pd_i;
        end
        if (load_i == QDC_LOAD_SEL && i == int'(sel_i))
        begin
          dr[i] <= merged;
          dr_pd[i] <= pd_i;
        end
        else if (load_i != QDC_LOAD_NONE && load_i != QDC_LOAD_SEL)
        begin
          dr[i] <= (i == int'(sel_i)) ? merged : tr[i];
          dr_pd[i] <= (i == int'(sel_i)) ? pd_i : tr_pd[i];
        end
      end
    end
  end

  // registered outputs: amplifier off and resistor chosen while powered down
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < CHANNELS; i++)
    begin
      if (rst_i)
      begin
        code_o[i*8 +: 8] <= QDC_BYTE_RESET;
        amp_en_o[i] <= 1'b1;
        pull_1k_o[i] <= 1'b0;
        pull_100k_o[i] <= 1'b0;
      end
      else if (ce_i)
      begin
        code_o[i*8 +: 8] <= dr[i][7:0];
        amp_en_o[i] <= ~dr_pd[i];
        pull_1k_o[i] <= dr_pd[i] && dr[i][9:8] == QDC_MODE_1K;
        pull_100k_o[i] <= dr_pd[i] && dr[i][9:8] == QDC_MODE_100K;
      end
    end
  end

  // readback mirrors the selected output register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rb_pd_o <= 1'b0;
      rb_mode_o <= 2'b00;
      rb_code_o <= QDC_BYTE_RESET;
    end
    else if (ce_i)
    begin
      rb_pd_o <= dr_pd[sel_i];
      rb_mode_o <= dr[sel_i][9:8];
      rb_code_o <= dr[sel_i][7:0];
    end
  end

  property p_pd_keeps_code;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && wr_i && pd_i) |=> tr[$past(sel_i)][7:0] == $past(tr[sel_i][7:0]);
  endproperty
  a_pd_keeps_code: assert property (p_pd_keeps_code) else $error("code changed on pd");

  property p_pd_mode_copy;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && wr_i && pd_i) |=> tr[$past(sel_i)][9:8] == $past(byte_i[7:6]);
  endproperty
  a_pd_mode_copy: assert property (p_pd_mode_copy) else $error("mode bits not copied");

  property p_pd_amp_off;
    @(posedge clk_i) disable iff (rst_i)
      (ce_i && dr_pd[0]) |=> (!amp_en_o[0] && !pull_1k_o[0] || dr[0][9:8] == QDC_MODE_1K);
  endproperty
  a_pd_amp_off: assert property (p_pd_amp_off) else $error("amp on in power-down");

  property p_reset_zero;
    @(posedge clk_i) rst_i |=> code_o == '0 && amp_en_o == '1;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset not zero");
endmodule

// ==== testbench/qdc_i2c_master.sv ====
// two-wire bus master model that runs on its own link clock
`timescale 1ns/1ps
module qdc_i2c_master (
  // link clock and wire level
  input wire logic link_clk_i,
  input wire logic sda_i,
  // open-drain drives, high idle
  output logic scl_o,
  output logic sda_low_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // quarter bit: two link cycles keep edges clear of the slave's pin filter delay
  task automatic quarter();
    repeat (2) @(posedge link_clk_i);
    #1;
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic start();
    sda_low_o = 1'b0;
    quarter();
    scl_o = 1'b1;
    quarter();
    sda_low_o = 1'b1;
    quarter();
    scl_o = 1'b0;
    quarter();
  endtask

  // stop: data rises while the clock is high; the clock then stands still
  task automatic stop();
    sda_low_o = 1'b1;
    quarter();
    scl_o = 1'b1;
    quarter();
    sda_low_o = 1'b0;
    quarter();
  endtask

  // one clock pulse; data set while low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_low_o = !b;
    quarter();
    scl_o = 1'b1;
    quarter();
    r = sda_i;
    quarter();
    scl_o = 1'b0;
    quarter();
  endtask

  // send a byte msb first; ack returns the wire level in the ninth slot
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, ack);
  endtask

  // receive a byte; acknowledge unless it is the last one
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

// ==== testbench/tb_qdc_serial_top.sv ====
// self-checking bench for the quad converter readback and power-down control
`timescale 1ns/1ps
module tb_qdc_serial_top;
  import qdc_pkg::*;
  localparam int CHANNELS = 4;
  localparam int MAX_CYCLES = 90000;
  logic sys_clk, sys_rst, ce, link_clk, scl, sda_low, sda_wire, sda_o, sda_oe;
  logic [1:0] addr_pin, addr_ext;
  logic [CHANNELS*8-1:0] code;
  logic [CHANNELS-1:0] amp_en, pull_1k, pull_100k;
  int err_count = 0;
  int check_count = 0;
  int cycles = 0;
  int ch;
  integer seed = 14384;
  // model registers: bit 10 power-down flag, 9:8 mode, 7:0 code
  int m_tmp[CHANNELS];
  int m_out[CHANNELS];

  // open-drain wire with pull-up
  assign sda_wire = (sda_low | (sda_oe & ~sda_o)) ? 1'b0 : 1'b1;

  qdc_serial_top #(.CHANNELS(CHANNELS)) qdc_serial_top_i (
    .SYS_CLK_I(sys_clk), .SYS_RST_I(sys_rst), .CE_I(ce),
    .SCL_I(scl), .SDA_I(sda_wire), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
    .ADDR_PIN_I(addr_pin), .ADDR_EXT_I(addr_ext), .CODE_O(code),
    .AMP_EN_O(amp_en), .PULL_1K_O(pull_1k), .PULL_100K_O(pull_100k));

  qdc_i2c_master qdc_i2c_master_i (
    .link_clk_i(link_clk), .sda_i(sda_wire), .scl_o(scl), .sda_low_o(sda_low));

  // system clock, and a link clock offset so the phases stay unrelated
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    link_clk = 1'b0;
    #7;
    forever #15 link_clk = ~link_clk;
  end

  task automatic finish_test();
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == MAX_CYCLES)
    begin
      err_count++;
      finish_test();
    end
  end

  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // analog-side pins against the model's output registers
  task automatic chk_pins();
    repeat (4) @(posedge sys_clk);
    #1;
    for (int i = 0; i < CHANNELS; i++)
    begin
      cmp_byte(code[i*8+:8], 8'(m_out[i]));
      cmp_bit(amp_en[i], !m_out[i][10]);
      cmp_bit(pull_1k[i], m_out[i][10] && m_out[i][9:8] == 2'h1);
      cmp_bit(pull_100k[i], m_out[i][10] && m_out[i][9:8] == 2'h2);
    end
  endtask

  // entry code, repeated start, write address and control byte
  task automatic hs_open(input logic [7:0] ctrl);
    logic a;
    qdc_i2c_master_i.start();
    qdc_i2c_master_i.wbyte({QDC_HS_CODE_TOP, 3'($random(seed))}, a);
    cmp_bit(a, 1'b1);
    qdc_i2c_master_i.start();
    qdc_i2c_master_i.wbyte({QDC_ADDR_FIXED, addr_pin, 1'b0}, a);
    cmp_bit(a, 1'b0);
    qdc_i2c_master_i.wbyte(ctrl, a);
    cmp_bit(a, 1'b0);
  endtask

  // one high/low data pair, then the model follows the load field
  task automatic wr(input int c, input logic pd, input logic [1:0] load, input logic [7:0] hi);
    logic a;
    hs_open({addr_ext, load, 1'b0, 2'(c), pd});
    qdc_i2c_master_i.wbyte(hi, a);
    cmp_bit(a, 1'b0);
    qdc_i2c_master_i.wbyte(8'($random(seed)), a);
    cmp_bit(a, 1'b0);
    qdc_i2c_master_i.stop();
    if (pd)
      m_tmp[c] = (m_tmp[c] & 'hFF) | 'h400 | (int'(hi[7:6]) << 8);
    else
      m_tmp[c] = int'(hi);
    if (load == QDC_LOAD_SEL)
      m_out[c] = m_tmp[c];
    else if (load[1])
      for (int i = 0; i < CHANNELS; i++)
        m_out[i] = m_tmp[i];
    chk_pins();
  endtask

  // readback of one channel; two or three bytes depending on the flag
  task automatic rd(input int c, input logic pd);
    logic a;
    logic [7:0] d;
    hs_open({addr_ext, QDC_LOAD_NONE, 1'b0, 2'(c), pd});
    qdc_i2c_master_i.start();
    qdc_i2c_master_i.wbyte({QDC_ADDR_FIXED, addr_pin, 1'b1}, a);
    cmp_bit(a, 1'b0);
    if (pd)
    begin
      qdc_i2c_master_i.rbyte(1'b0, d);
      cmp_byte(d, {2'(m_out[c] >> 8), 6'h3F});
    end
    qdc_i2c_master_i.rbyte(1'b0, d);
    cmp_byte(d, 8'(m_out[c]));
    qdc_i2c_master_i.rbyte(1'b1, d);
    cmp_bit(sda_oe, 1'b0);
    qdc_i2c_master_i.stop();
  endtask

  // main sequence
  initial
  begin
    logic a;
    sys_rst = 1'b1;
    ce = 1'b1;
    addr_pin = 2'($random(seed));
    addr_ext = 2'($random(seed));
    for (int i = 0; i < CHANNELS; i++)
    begin
      m_tmp[i] = 0;
      m_out[i] = 0;
    end
    repeat (8) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    chk_pins();
    rd(1, 1'b1);
    // a foreign address must be ignored
    qdc_i2c_master_i.start();
    qdc_i2c_master_i.wbyte({QDC_ADDR_FIXED, ~addr_pin, 1'b0}, a);
    cmp_bit(a, 1'b1);
    qdc_i2c_master_i.stop();
    // a write whose extended address differs is acked but not stored
    hs_open({~addr_ext, QDC_LOAD_SEL, 1'b0, 2'h0, 1'b0});
    qdc_i2c_master_i.wbyte(8'hFF, a);
    cmp_bit(a, 1'b0);
    qdc_i2c_master_i.wbyte(8'hFF, a);
    cmp_bit(a, 1'b0);
    qdc_i2c_master_i.stop();
    chk_pins();
    // every power-down mode, each after a normal update of the same channel
    for (int k = 0; k < 4; k++)
    begin
      ch = $random(seed) & 3;
      wr(ch, 1'b0, QDC_LOAD_SEL, 8'($random(seed)));
      rd(ch, 1'b0);
      wr(ch, 1'b1, QDC_LOAD_SEL, {2'(k), 6'($random(seed))});
      rd(ch, 1'b1);
    end
    // stage data in a temporary register, then broadcast a power-down
    wr(0, 1'b0, QDC_LOAD_NONE, 8'($random(seed)));
    wr(3, 1'b1, 2'h2, 8'h5A);
    rd(0, 1'b0);
    rd(3, 1'b1);
    // the second broadcast load encoding
    wr(2, 1'b0, 2'h3, 8'($random(seed)));
    rd(2, 1'b0);
    finish_test();
  end
endmodule
